/* rtl/cmt_pkg.sv */
package cmt_pkg;
  // ************
  // Register map
  // ************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PICK = 8'h04;
  localparam logic [7:0] A_WORD = 8'h08;
  localparam logic [7:0] A_SAT = 8'h0c;
  localparam logic [7:0] A_WBR = 8'h10;
  localparam logic [7:0] A_WBB = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam int NREG = 7;
  // Control word fields
  localparam int B_PIPE = 0;
  localparam int B_UNIT = 1;
  localparam int B_XON = 2;
  localparam int B_BOOST = 3;
  localparam int B_YUVF = 4;
  localparam int B_GAMMA = 5;
  localparam int P_LSB = 8;
  localparam logic [2:0] PRESET_CUSTOM = 3'h7;
  localparam logic [3:0] NCOEF = 4'hc;
  // Reset values, response codes and FIFO depth
  localparam logic [7:0] SAT_RST = 8'h10;
  localparam logic [31:0] F_ONE = 32'h3f800000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int FIFO_DEPTH = 4;
  // ************
  // Types
  // ************
  typedef struct packed {
    logic sof;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_t;
  typedef struct packed {
    logic rgb;
    logic boost;
    logic gam;
    logic yuv;
    logic [7:0] sat;
  } mode_t;
  typedef struct packed {
    logic v;
    pixel_t p;
    mode_t m;
  } stage_t;
  typedef logic [11:0][31:0] coef_w_t;
  typedef logic signed [11:0][19:0] coef_fx_t;
  // Luma/chroma matrix, gains row by row, then offsets
  localparam coef_w_t YUV_W = {
    32'h43000000, 32'h43000000, 32'h00000000,
    32'hbda6872b, 32'hbed65d68, 32'h3f000000,
    32'h3f000000, 32'hbea99a5b, 32'hbe2cc8c5,
    32'h3de978d5, 32'h3f1645a2, 32'h3e991687};
endpackage : cmt_pkg

/* rtl/color_matrix_transform.sv */
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
module cmt_fifo #(
  parameter int W = 25,
  parameter int D = 4
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic in_valid, // Push request
  input wire logic [W-1:0] in_data, // Push data
  output logic in_ready, // Room left
  output logic out_valid, // Head valid
  output logic [W-1:0] out_data, // Head data
  input wire logic out_ready, // Pop request
  output logic [$clog2(D+1)-1:0] level // Words held
);
  logic [D-1:0][W-1:0] mem_r;
  logic [D-1:0] vld_r;
  logic [$clog2(D+1)-1:0] cnt_r, cnt_nxt, wp;
  logic push, pop;
  // Head always sits in slot zero
  assign pop = vld_r[0] && out_ready;
  assign push = in_valid && !vld_r[D-1];
  assign wp = cnt_r - {{($clog2(D+1)-1){1'b0}}, pop};
  assign cnt_nxt = wp + {{($clog2(D+1)-1){1'b0}}, push};
  assign in_ready = !vld_r[D-1];
  assign out_valid = vld_r[0];
  assign out_data = mem_r[0];
  assign level = cnt_r;
  // Shift on pop, write into first free slot
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_r <= '0;
      vld_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      for (int i = 0; i < D; i++) begin
        vld_r[i] <= (i < int'(cnt_nxt));
      end
    end
  end
  // Storage has no reset
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < D; i++) begin
      if (push && i == int'(wp)) mem_r[i] <= in_data;
      else if (pop && i < D - 1) mem_r[i] <= mem_r[i+1];
    end
  end
endmodule : cmt_fifo

module color_matrix_transform (
  input wire logic sys_clk, // Pipeline clock
  input wire logic reset_n, // Sync reset
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Response valid
  input wire logic bready, // Response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read valid
  input wire logic rready, // Read ready
  input wire cmt_pkg::pixel_t pix_in, // Upstream pixel
  input wire logic pix_in_valid, // Upstream valid
  output logic pix_in_ready, // Credit to upstream
  output cmt_pkg::pixel_t pix_out, // Downstream pixel
  output logic pix_out_valid, // Downstream valid
  input wire logic pix_out_ready // Downstream ready
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_got_r, w_got_r, in_ready_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] wa_r, sat_r;
  logic [31:0] wd_r, rdata_r, wbr_r, wbb_r, wv, word_rd;
  logic [3:0] ws_r, pick_r, wa_idx, ra_idx;
  logic pipe_r, unit_r, rgbon_r, boost_r, yuvf_r, gam_r;
  logic [2:0] preset_r;
  logic [15:0] frames_r;
  localparam int NREG = cmt_pkg::NREG;
  logic wa_ok, ra_ok, wr_fire, acc, acc_px, frame_edge, f_rdy;
  logic [NREG-1:0][31:0] view;
  cmt_pkg::coef_w_t user_w_r, act_w_r;
  cmt_pkg::coef_fx_t act_fx, yuv_fx;
  cmt_pkg::mode_t fm_r, live;
  cmt_pkg::stage_t s0_r, s1_r, s2_r, s3_r, s4_r;
  logic [2:0] lvl;

  // ************
  // Helpers
  // ************
  function automatic logic [4:0] dec(input logic [7:0] a);
    dec = {a[1:0] == 2'h0 && a[7:2] < 6'(NREG), a[5:2]};
  endfunction : dec
  function automatic logic signed [19:0] f2x(input logic [31:0] f);
    logic [31:0] m;
    logic [31:0] v;
    int sh;
    m = {8'h00, 1'b1, f[22:0]};
    sh = int'(f[30:23]) - 142;
    v = 32'h0;
    if (f[30:23] == 8'h00) v = 32'h0;
    else if (sh > 8) v = 32'h0007ffff;
    else if (sh >= 0) v = m << sh;
    else if (sh > -24) v = m >> (-sh);
    if (v > 32'h0007ffff) v = 32'h0007ffff;
    f2x = f[31] ? -signed'(v[19:0]) : signed'(v[19:0]);
  endfunction : f2x
  function automatic logic [7:0] clip8(input logic signed [31:0] x);
    clip8 = x < 0 ? 8'h00 : (x > 255 ? 8'hff : x[7:0]);
  endfunction : clip8
  // Matrix row times RGB plus offset, Q.8 coefficients
  function automatic cmt_pkg::pixel_t mat3(input cmt_pkg::coef_fx_t k,
                                           input cmt_pkg::pixel_t p);
    logic signed [31:0] s;
    logic signed [8:0] x, y, z;
    logic [2:0][7:0] o;
    x = $signed({1'b0, p.r});
    y = $signed({1'b0, p.g});
    z = $signed({1'b0, p.b});
    for (int j = 0; j < 3; j++) begin
      // Elements of a packed array are unsigned, so re-sign each one
      s = $signed(k[3*j]) * x + $signed(k[3*j+1]) * y +
          $signed(k[3*j+2]) * z + $signed(k[9+j]);
      o[j] = clip8(s >>> 8);
    end
    mat3 = p;
    mat3.r = o[0];
    mat3.g = o[1];
    mat3.b = o[2];
  endfunction : mat3
  function automatic logic [7:0] boost(input logic [7:0] c,
                                       input logic [9:0] l,
                                       input logic [7:0] k);
    logic signed [31:0] d;
    d = ($signed({1'b0, c}) - $signed({1'b0, l})) * $signed({1'b0, k});
    boost = clip8($signed({1'b0, l}) + (d >>> 4));
  endfunction : boost
  function automatic logic [7:0] gam(input logic [7:0] x);
    logic [15:0] t;
    t = 16'(x) * 16'(8'hff - x);
    gam = x + t[15:8];
  endfunction : gam
  // Preset words 0..11 are matrix, 12/13 balance ratios
  function automatic logic [31:0] pword(input logic [2:0] p,
                                        input int i);
    logic [3:0][31:0] d;
    unique case (p)
      3'h1: d = {32'h3f400000, 32'h3fc00000, 32'h3f000000, 32'h40000000};
      3'h2: d = {32'h3f600000, 32'h3fa00000, 32'h3f400000, 32'h3fc00000};
      3'h3: d = {32'h3f800000, 32'h3f900000, 32'h3f800000, 32'h3fa00000};
      3'h5: d = {32'h3f900000, 32'h3f600000, 32'h3fc00000, 32'h3f400000};
      3'h6: d = {32'h3fa00000, 32'h3f400000, 32'h40000000, 32'h3f000000};
      default: d = {4{cmt_pkg::F_ONE}};
    endcase
    pword = i == 0 ? d[3] : i == 4 ? cmt_pkg::F_ONE : i == 8 ? d[2] :
            i == 12 ? d[1] : i == 13 ? d[0] : 32'h0;
  endfunction : pword
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b+:8] = n[8*b+:8];
    end
    merge = o;
  endfunction : merge

  // ************
  // Register bus
  // ************
  assign {wa_ok, wa_idx} = dec(wa_r);
  assign {ra_ok, ra_idx} = dec(araddr);
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wv = merge(view[wa_idx[2:0]], wd_r, ws_r);
  assign acc = wr_fire && wa_ok && pipe_r;
  // Register view for reads and byte merges
  always_comb begin
    view = '0;
    view[0][cmt_pkg::B_PIPE] = pipe_r;
    view[0][cmt_pkg::B_UNIT] = unit_r;
    view[0][cmt_pkg::B_XON] = unit_r ? yuvf_r : rgbon_r;
    view[0][cmt_pkg::B_BOOST] = boost_r;
    view[0][cmt_pkg::B_YUVF] = yuvf_r;
    view[0][cmt_pkg::B_GAMMA] = gam_r;
    view[0][cmt_pkg::P_LSB+:3] = preset_r;
    view[1][3:0] = pick_r;
    view[2] = word_rd;
    view[3][7:0] = sat_r;
    view[4] = wbr_r;
    view[5] = wbb_r;
    view[6] = {13'h0, lvl, frames_r};
  end
  // Readback of the coefficient in use
  assign word_rd = pick_r >= cmt_pkg::NCOEF ? 32'h0 :
                   unit_r ? cmt_pkg::YUV_W[pick_r] : act_w_r[pick_r];
  // Address and data channels, taken in either order
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
    end else begin
      awready_r <= awvalid && !awready_r && !aw_got_r;
      wready_r <= wvalid && !wready_r && !w_got_r;
      if (awvalid && awready_r) begin
        aw_got_r <= 1'b1;
        wa_r <= awaddr;
      end else if (wr_fire) aw_got_r <= 1'b0;
      if (wvalid && wready_r) begin
        w_got_r <= 1'b1;
        wd_r <= wdata;
        ws_r <= wstrb;
      end else if (wr_fire) w_got_r <= 1'b0;
    end
  end
  // Write and read responses
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= cmt_pkg::RESP_OK;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= cmt_pkg::RESP_OK;
      rdata_r <= 32'h0;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wa_ok ? cmt_pkg::RESP_OK : cmt_pkg::RESP_ERR;
      end else if (bready) bvalid_r <= 1'b0;
      arready_r <= arvalid && !arready_r && !rvalid_r;
      if (arvalid && arready_r) begin
        rvalid_r <= 1'b1;
        rresp_r <= ra_ok ? cmt_pkg::RESP_OK : cmt_pkg::RESP_ERR;
        rdata_r <= ra_ok && (pipe_r || ra_idx == 4'h0) ?
                   view[ra_idx[2:0]] : 32'h0;
      end else if (rready) rvalid_r <= 1'b0;
    end
  end
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ************
  // Control state
  // ************
  // Control word; pipe bit always writable
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      {pipe_r, unit_r, rgbon_r, boost_r, yuvf_r, gam_r} <= 6'h00;
      preset_r <= 3'h0;
    end else if (wr_fire && wa_ok && wa_idx == 4'h0) begin
      pipe_r <= wv[cmt_pkg::B_PIPE];
      if (pipe_r) begin
        unit_r <= wv[cmt_pkg::B_UNIT];
        if (!unit_r) rgbon_r <= wv[cmt_pkg::B_XON];
        boost_r <= wv[cmt_pkg::B_BOOST];
        yuvf_r <= wv[cmt_pkg::B_YUVF];
        gam_r <= wv[cmt_pkg::B_GAMMA];
        preset_r <= wv[cmt_pkg::P_LSB+:3];
      end
    end
  end
  // Pick, saturation and balance ratios
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pick_r <= 4'h0;
      sat_r <= cmt_pkg::SAT_RST;
      wbr_r <= cmt_pkg::F_ONE;
      wbb_r <= cmt_pkg::F_ONE;
    end else if (acc) begin
      if (wa_idx == 4'h1) pick_r <= wv[3:0];
      if (wa_idx == 4'h3) sat_r <= wv[7:0];
      if (wa_idx == 4'h4) wbr_r <= wv;
      if (wa_idx == 4'h5) wbb_r <= wv;
      if (wa_idx == 4'h0 && wv[cmt_pkg::P_LSB+:3] != preset_r) begin
        wbr_r <= pword(wv[cmt_pkg::P_LSB+:3], 12);
        wbb_r <= pword(wv[cmt_pkg::P_LSB+:3], 13);
      end
    end
  end
  // User coefficients held as float words
  always_ff @(posedge sys_clk) begin
    if (!reset_n) user_w_r <= '0;
    else if (acc && wa_idx == 4'h2 && !unit_r &&
             preset_r == cmt_pkg::PRESET_CUSTOM &&
             pick_r < cmt_pkg::NCOEF) user_w_r[pick_r] <= wv;
  end
  // Active matrix loads at each frame start
  assign frame_edge = acc_px && pix_in.sof;
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 12; i++) begin
      if (!reset_n) act_w_r[i] <= pword(3'h0, i);
      else if (frame_edge)
        act_w_r[i] <= preset_r == cmt_pkg::PRESET_CUSTOM ?
                      user_w_r[i] : pword(preset_r, i);
    end
  end
  // Float to fixed for both units
  for (genvar i = 0; i < 12; i++) begin : g_cvt
    assign act_fx[i] = f2x(act_w_r[i]);
    assign yuv_fx[i] = f2x(cmt_pkg::YUV_W[i]);
  end

  // ************
  // Pixel path
  // ************
  assign live = '{rgb: rgbon_r, boost: boost_r, gam: gam_r, yuv: yuvf_r,
                  sat: sat_r};
  assign acc_px = pix_in_valid && in_ready_r;
  // Input stage and frame mode latch
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s0_r <= '0;
      fm_r <= '0;
      frames_r <= 16'h0;
    end else begin
      s0_r <= '{v: acc_px, p: pix_in, m: pix_in.sof ? live : fm_r};
      if (frame_edge) fm_r <= live;
      frames_r <= frames_r + 16'(frame_edge);
    end
  end
  // Correction, saturation, gamma, then luma/chroma
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      s4_r <= '0;
    end else begin
      s1_r <= s0_r;
      if (s0_r.m.rgb) s1_r.p <= mat3(act_fx, s0_r.p);
      s2_r <= s1_r;
      if (s1_r.m.boost) begin
        s2_r.p.r <= boost(s1_r.p.r, 10'((s1_r.p.r + 2 * s1_r.p.g +
                    s1_r.p.b) >> 2), s1_r.m.sat);
        s2_r.p.g <= boost(s1_r.p.g, 10'((s1_r.p.r + 2 * s1_r.p.g +
                    s1_r.p.b) >> 2), s1_r.m.sat);
        s2_r.p.b <= boost(s1_r.p.b, 10'((s1_r.p.r + 2 * s1_r.p.g +
                    s1_r.p.b) >> 2), s1_r.m.sat);
      end
      s3_r <= s2_r;
      if (s2_r.m.gam) begin
        s3_r.p.r <= gam(s2_r.p.r);
        s3_r.p.g <= gam(s2_r.p.g);
        s3_r.p.b <= gam(s2_r.p.b);
      end
      s4_r <= s3_r;
      if (s3_r.m.yuv) s4_r.p <= mat3(yuv_fx, s3_r.p);
    end
  end
  // Credit keeps pipe plus FIFO within depth
  always_ff @(posedge sys_clk) begin
    if (!reset_n) in_ready_r <= 1'b0;
    else in_ready_r <= f_rdy && (int'(lvl) + int'(s0_r.v) + int'(s1_r.v)
                       + int'(s2_r.v) + int'(s3_r.v) + int'(s4_r.v)
                       + int'(acc_px) + 1 <= cmt_pkg::FIFO_DEPTH);
  end
  assign pix_in_ready = in_ready_r;

  cmt_fifo #(.W($bits(cmt_pkg::pixel_t)), .D(cmt_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(s4_r.v),
    .in_data(s4_r.p),
    .in_ready(f_rdy),
    .out_valid(pix_out_valid),
    .out_data(pix_out),
    .out_ready(pix_out_ready),
    .level(lvl)
  );

  // ************
  // Assertions
  // ************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_bypass_pass: assert property (s0_r.v && !s0_r.m.rgb |=>
    s1_r.p == $past(s0_r.p)) else $error("bypass altered pixel");
  a_fixed_latency: assert property (acc_px |-> ##5 s4_r.v)
    else $error("latency not five");
  a_custom_gate: assert property (wr_fire && preset_r !=
    cmt_pkg::PRESET_CUSTOM |=> $stable(user_w_r))
    else $error("user coefficient written off custom");
  a_yuv_enable_ro: assert property (wr_fire && unit_r |=>
    $stable(rgbon_r)) else $error("enable changed under yuv");
  a_pipe_gate: assert property (wr_fire && !pipe_r |=>
    $stable(pick_r) && $stable(sat_r) && $stable(preset_r))
    else $error("control written with pipe off");
  a_preset_wb: assert property (acc && wa_idx == 4'h0 &&
    wv[cmt_pkg::P_LSB+:3] != preset_r |=>
    wbr_r == pword(preset_r, 12)) else $error("ratio not loaded");
  a_frame_latch: assert property (!frame_edge |=>
    $stable(act_w_r)) else $error("matrix changed mid frame");
  a_fifo_room: assert property (s4_r.v |-> f_rdy)
    else $error("fifo overflow");
  a_yuv_only: assert property (s3_r.v && !s3_r.m.yuv |=>
    s4_r.p == $past(s3_r.p)) else $error("yuv applied off format");
  c_frame: cover property (frame_edge ##[1:20] frame_edge);
  c_yuv_px: cover property (s4_r.v && s4_r.m.yuv && s4_r.m.rgb);
  c_custom: cover property (acc && wa_idx == 4'h2 &&
    preset_r == cmt_pkg::PRESET_CUSTOM);
  c_full: cover property (lvl == 3'h4 && !pix_out_ready);
endmodule : color_matrix_transform

/* test/pixel_partner.sv */
`timescale 1ns/1ns
// ************************
// Upstream and downstream stages
// ************************
module pixel_partner (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic [1:0] stall, // Random stall bits
  output cmt_pkg::pixel_t pix_in, // Pixel to block
  output logic pix_in_valid, // Source valid
  input wire logic pix_in_ready, // Block credit
  input wire cmt_pkg::pixel_t pix_out, // Pixel from block
  input wire logic pix_out_valid, // Block valid
  output logic pix_out_ready // Sink ready
);
  cmt_pkg::pixel_t src_q[$];
  cmt_pkg::pixel_t rcv_q[$];
  // Source holds each pixel until taken, scrambles when idle
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pix_in_valid <= 1'b0;
      pix_in <= '0;
    end else if (!pix_in_valid || pix_in_ready) begin
      if (src_q.size() > 0 && !stall[0]) begin
        pix_in_valid <= 1'b1;
        pix_in <= src_q.pop_front();
      end else begin
        pix_in_valid <= 1'b0;
        pix_in <= ~pix_in;
      end
    end
  end
  // Sink stalls at random and collects in arrival order
  always @(posedge sys_clk) begin
    pix_out_ready <= reset_n && !stall[1];
    if (reset_n && pix_out_valid && pix_out_ready) begin
      rcv_q.push_back(pix_out);
    end
  end
endmodule : pixel_partner

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  // ************
  // Signals
  // ************
  logic sys_clk;
  logic reset_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  cmt_pkg::pixel_t pix_in, pix_out;
  logic pix_in_valid, pix_in_ready, pix_out_valid, pix_out_ready;
  logic [1:0] stall = 2'h0;
  logic [31:0] seed = 32'h18c3b623;
  int n_errors = 0;
  int n_tests = 0;
  int i;

  color_matrix_transform u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_out(pix_out),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));

  pixel_partner u_partner (.sys_clk(sys_clk), .reset_n(reset_n),
    .stall(stall), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_out(pix_out),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));

  // ************
  // Clock and random back-pressure
  // ************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  // Seed steps every cycle; stall bits follow it
  always @(posedge sys_clk) begin
    seed <= xorshift(seed);
    stall <= seed[1:0];
  end

  // ************
  // Checking and closing
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic tmo;
    n_errors++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
    end_of_test();
  endtask : tmo

  // ************
  // Register bus master
  // ************
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = cmt_pkg::RESP_OK);
    int k;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 64) tmo();
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = cmt_pkg::RESP_OK);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 64) tmo();
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask : rchk

  // ************
  // Pixel frames
  // ************
  // Mode 0 pass-through, 1 custom matrix, 2 full desaturation, 3 gamma
  function automatic cmt_pkg::pixel_t expect_pix(input cmt_pkg::pixel_t p,
                                                input int md);
    cmt_pkg::pixel_t o;
    int l;
    o = p;
    l = (int'(p.r) + 2 * int'(p.g) + int'(p.b)) / 4;
    if (md == 1) begin
      o.r = (p.r > 8'h7f) ? 8'hff : 8'(2 * int'(p.r));
      o.b = (p.b > 8'hef) ? 8'hff : p.b + 8'h10;
    end
    if (md == 2) begin
      o.r = 8'(l);
      o.g = 8'(l);
      o.b = 8'(l);
    end
    if (md == 3) begin
      o.r = 8'(int'(p.r) + int'(p.r) * (255 - int'(p.r)) / 256);
      o.g = 8'(int'(p.g) + int'(p.g) * (255 - int'(p.g)) / 256);
      o.b = 8'(int'(p.b) + int'(p.b) * (255 - int'(p.b)) / 256);
    end
    return o;
  endfunction : expect_pix

  task automatic run_frame(input int md, input int n);
    cmt_pkg::pixel_t p;
    cmt_pkg::pixel_t q[$];
    int k;
    for (k = 0; k < n; k++) begin
      @(negedge sys_clk);
      p = seed[24:0];
      p.sof = (k == 0);
      q.push_back(expect_pix(p, md));
      u_partner.src_q.push_back(p);
    end
    for (k = 0; k < 400 && u_partner.rcv_q.size() < n; k++) begin
      @(posedge sys_clk);
    end
    if (k == 400) tmo();
    for (k = 0; k < n; k++) begin
      chk(32'(u_partner.rcv_q.pop_front()), 32'(q[k]));
    end
    $display("frame in mode %0d done", md);
  endtask : run_frame

  // ************
  // Main sequence
  // ************
  initial begin
    reset_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    // Pipe off hides the controls
    rchk(cmt_pkg::A_CTRL, 32'h0);
    wr(cmt_pkg::A_SAT, 32'h55);
    rchk(cmt_pkg::A_SAT, 32'h0);
    wr(cmt_pkg::A_CTRL, 32'h1);
    rchk(cmt_pkg::A_SAT, 32'(cmt_pkg::SAT_RST));
    rchk(cmt_pkg::A_WBR, cmt_pkg::F_ONE);
    rchk(8'h1c, 32'h0, cmt_pkg::RESP_ERR);
    wr(8'h20, 32'h0, cmt_pkg::RESP_ERR);
    $display("access test done");
    // General preset reads back an identity matrix
    for (i = 0; i < 12; i++) begin
      wr(cmt_pkg::A_PICK, 32'(i));
      rchk(cmt_pkg::A_WORD, (i % 4 == 0 && i < 9) ? cmt_pkg::F_ONE : 0);
    end
    wr(cmt_pkg::A_PICK, 32'h1);
    wr(cmt_pkg::A_WORD, 32'h40000000);
    // Custom preset: r gain 2.0, g and b 1.0, b offset 16.0
    wr(cmt_pkg::A_CTRL, 32'h705);
    for (i = 0; i < 4; i++) begin
      wr(cmt_pkg::A_PICK, (i == 3) ? 32'hb : 32'(4 * i));
      wr(cmt_pkg::A_WORD, (i == 0) ? 32'h40000000 :
         (i == 3) ? 32'h41800000 : cmt_pkg::F_ONE);
    end
    run_frame(1, 10);
    wr(cmt_pkg::A_PICK, 32'h0);
    rchk(cmt_pkg::A_WORD, 32'h40000000);
    wr(cmt_pkg::A_PICK, 32'h1);
    rchk(cmt_pkg::A_WORD, 32'h0);
    // Boost with zero saturation, then boost off
    wr(cmt_pkg::A_SAT, 32'h0);
    wr(cmt_pkg::A_CTRL, 32'h9);
    run_frame(2, 10);
    wr(cmt_pkg::A_CTRL, 32'h1);
    run_frame(0, 10);
    rchk(cmt_pkg::A_STAT, 32'h3);
    // Gamma on, luma/chroma off: gamma output passes unchanged
    wr(cmt_pkg::A_CTRL, 32'h21);
    run_frame(3, 10);
    // Luma/chroma unit: enable is read-only, constants read back
    wr(cmt_pkg::A_CTRL, 32'h7);
    rchk(cmt_pkg::A_CTRL, 32'h3);
    wr(cmt_pkg::A_CTRL, 32'h13);
    rchk(cmt_pkg::A_CTRL, 32'h17);
    for (i = 0; i < 12; i++) begin
      wr(cmt_pkg::A_PICK, 32'(i));
      rchk(cmt_pkg::A_WORD, cmt_pkg::YUV_W[i]);
    end
    // Manual balance ratio survives an unchanged preset
    wr(cmt_pkg::A_WBR, 32'h3fc00000);
    wr(cmt_pkg::A_CTRL, 32'h13);
    rchk(cmt_pkg::A_WBR, 32'h3fc00000);
    $display("register test done");
    end_of_test();
  end
endmodule : testbench
